// >>> logic/airs_chan_decode.sv
// Purpose: registered decode of the 6-bit channel/gain code
// Assumes: code is stable while a conversion runs
// Notes:   upper half mirrors the lower half with inputs offset by 8, except codes 0x3E/0x3F, which decode as reserved
`timescale 1ns/1ps
module airs_chan_decode (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [5:0]          code,
    output logic                     single_ended_q,
    output logic                     differential_q,
    output logic [3:0]               pos_input_q,
    output logic [3:0]               neg_input_q,
    output airs_pkg::airs_gain_t     gain_q,
    output logic                     bandgap_q,
    output logic                     ground_q,
    output logic                     reserved_q
);
    logic [3:0]           ofs;
    logic                 se_d, df_d, bg_d, gnd_d, rsv_d;
    logic [3:0]           pos_d, neg_d;
    airs_pkg::airs_gain_t gain_d;

    always_comb begin
        ofs    = {code[5], 3'b000};
        se_d   = 1'b0;
        df_d   = 1'b0;
        bg_d   = 1'b0;
        gnd_d  = 1'b0;
        rsv_d  = 1'b0;
        pos_d  = 4'h0;
        neg_d  = 4'h0;
        gain_d = airs_pkg::AIRS_GAIN_1X;
        case (code[4:3])
            2'b00: begin
                se_d  = 1'b1;
                pos_d = {1'b0, code[2:0]} | ofs;
            end
            2'b01: begin
                df_d   = 1'b1;
                pos_d  = {2'b00, code[2], code[0]} | ofs;
                neg_d  = {2'b00, code[2], 1'b0} | ofs;
                gain_d = code[1] ? airs_pkg::AIRS_GAIN_200X : airs_pkg::AIRS_GAIN_10X;
            end
            2'b10: begin
                df_d  = 1'b1;
                pos_d = {1'b0, code[2:0]} | ofs;
                neg_d = 4'h1 | ofs;
            end
            default: begin
                if (code[2:1] != 2'b11) begin
                    df_d  = 1'b1;
                    pos_d = {1'b0, code[2:0]} | ofs;
                    neg_d = 4'h2 | ofs;
                end else if (!code[5]) begin
                    bg_d  = (code[4:0] == airs_pkg::CODE_BANDGAP);
                    gnd_d = (code[4:0] == airs_pkg::CODE_GROUND);
                end else begin
                    rsv_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            single_ended_q <= 1'b0;
            differential_q <= 1'b0;
            pos_input_q    <= 4'h0;
            neg_input_q    <= 4'h0;
            gain_q         <= airs_pkg::AIRS_GAIN_1X;
            bandgap_q      <= 1'b0;
            ground_q       <= 1'b0;
            reserved_q     <= 1'b0;
        end else begin
            single_ended_q <= se_d;
            differential_q <= df_d;
            pos_input_q    <= pos_d;
            neg_input_q    <= neg_d;
            gain_q         <= gain_d;
            bandgap_q      <= bg_d;
            ground_q       <= gnd_d;
            reserved_q     <= rsv_d;
        end
    end
endmodule

// >>> logic/airs_pkg.sv
// Purpose: shared constants and types of the converter input/reference select block
// Assumes: register indices are byte address / 4
// Notes:   none
package airs_pkg;
    // ***************************************************
    // register indices
    // ***************************************************
    localparam logic [7:0] IDX_RES_LO   = 8'h78;
    localparam logic [7:0] IDX_RES_HI   = 8'h79;
    localparam logic [7:0] IDX_CTRL_B   = 8'h7B;
    localparam logic [7:0] IDX_SEL      = 8'h7C;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h81;
    // ***************************************************
    // fields and reset values
    // ***************************************************
    localparam int         SEL_REF_HI   = 7;
    localparam int         SEL_REF_LO   = 6;
    localparam int         SEL_ALIGN    = 5;
    localparam int         SEL_CH_HI    = 4;
    localparam int         CTLB_TOP     = 3;
    localparam logic [7:0] CTLB_WMASK   = 8'h4F;
    localparam logic [7:0] SEL_RST      = 8'h00;
    localparam logic [7:0] CTLB_RST     = 8'h00;
    localparam logic       MASK_RST     = 1'h0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam logic [4:0] CODE_BANDGAP = 5'h1E;
    localparam logic [4:0] CODE_GROUND  = 5'h1F;
    // ***************************************************
    // types
    // ***************************************************
    typedef enum logic [1:0] {
        AIRS_REF_EXT    = 2'b00,
        AIRS_REF_SUPPLY = 2'b01,
        AIRS_REF_1V1    = 2'b10,
        AIRS_REF_2V56   = 2'b11
    } airs_ref_t;
    typedef enum logic [1:0] {
        AIRS_GAIN_1X   = 2'b00,
        AIRS_GAIN_10X  = 2'b01,
        AIRS_GAIN_200X = 2'b10
    } airs_gain_t;
    typedef enum logic [0:0] {
        AIRS_WR_IDLE = 1'b0,
        AIRS_WR_RESP = 1'b1
    } airs_wr_t;
endpackage

// >>> logic/airs_top.sv
// Purpose: reference, channel/gain and alignment control of the converter
// Assumes: conv_busy/conv_done/conv_result come from logic on clk_sys
// Notes:   AXI4-Lite slave, one write and one read outstanding
`timescale 1ns/1ps
module airs_top #(
    parameter int ADDR_W    = 12,
    parameter bit HAS_UPPER = 1'b1
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                conv_busy,
    input  wire logic                conv_done,
    input  wire logic [9:0]          conv_result,
    output airs_pkg::airs_ref_t      reference_select,
    output logic [5:0]               channel_code,
    output logic                     single_ended,
    output logic                     differential,
    output logic [3:0]               pos_input,
    output logic [3:0]               neg_input,
    output airs_pkg::airs_gain_t     gain,
    output logic                     bandgap_source,
    output logic                     ground_select,
    output logic                     reserved_code,
    output logic                     result_is_signed,
    output logic                     irq
);
    // ***************************************************
    // state
    // ***************************************************
    logic [7:0]          sel_q;
    logic [7:0]          ctlb_q;
    logic [9:0]          result_q;
    logic                signed_q;
    logic                done_q;
    logic                mask_q;
    airs_pkg::airs_ref_t ref_q;
    logic [5:0]          code_q;
    logic [5:0]          code_d;
    logic                apply;
    airs_pkg::airs_wr_t  wr_st_q;
    logic                aw_have_q;
    logic                w_have_q;
    logic [ADDR_W-1:0]   awaddr_q;
    logic [7:0]          wdata_q;
    logic                wlane_q;
    logic [1:0]          bresp_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;
    logic                rvalid_q;
    logic                wr_go;
    logic [7:0]          wr_idx;
    logic [7:0]          rd_word;
    logic                done_clr;

    // ***************************************************
    // address decode
    // ***************************************************
    function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
        idx_of = a[9:2];
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0)
            && (i == airs_pkg::IDX_RES_LO || i == airs_pkg::IDX_RES_HI
            || i == airs_pkg::IDX_CTRL_B || i == airs_pkg::IDX_SEL
            || i == airs_pkg::IDX_IRQ_STAT || i == airs_pkg::IDX_IRQ_MASK);
    endfunction

    // ***************************************************
    // write channel
    // ***************************************************
    assign s_axi_awready = !aw_have_q && (wr_st_q == airs_pkg::AIRS_WR_IDLE);
    assign s_axi_wready  = !w_have_q && (wr_st_q == airs_pkg::AIRS_WR_IDLE);
    assign s_axi_bvalid  = (wr_st_q == airs_pkg::AIRS_WR_RESP);
    assign s_axi_bresp   = bresp_q;
    assign wr_go         = aw_have_q && w_have_q;
    assign wr_idx        = idx_of(awaddr_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_st_q   <= airs_pkg::AIRS_WR_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bresp_q   <= airs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wlane_q  <= s_axi_wstrb[0];
            end
            case (wr_st_q)
                airs_pkg::AIRS_WR_IDLE: begin
                    if (wr_go) begin
                        wr_st_q   <= airs_pkg::AIRS_WR_RESP;
                        aw_have_q <= 1'b0;
                        w_have_q  <= 1'b0;
                        bresp_q   <= mapped(awaddr_q) ? airs_pkg::RESP_OKAY : airs_pkg::RESP_SLVERR;
                    end
                end
                default: begin
                    if (s_axi_bready) begin
                        wr_st_q <= airs_pkg::AIRS_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ***************************************************
    // software registers
    // ***************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_q  <= airs_pkg::SEL_RST;
            ctlb_q <= airs_pkg::CTLB_RST;
            mask_q <= airs_pkg::MASK_RST;
        end else if (wr_go && wlane_q && wr_st_q == airs_pkg::AIRS_WR_IDLE) begin
            if (wr_idx == airs_pkg::IDX_SEL) begin
                sel_q <= wdata_q;
            end else if (wr_idx == airs_pkg::IDX_CTRL_B) begin
                ctlb_q <= wdata_q & airs_pkg::CTLB_WMASK;
            end else if (wr_idx == airs_pkg::IDX_IRQ_MASK) begin
                mask_q <= wdata_q[0];
            end
        end
    end

    assign done_clr = wr_go && wlane_q && (wr_st_q == airs_pkg::AIRS_WR_IDLE)
        && (wr_idx == airs_pkg::IDX_IRQ_STAT) && wdata_q[0];

    // set wins over a same-cycle clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= conv_done || (done_q && !done_clr);
        end
    end

    assign irq = done_q && mask_q;

    // ***************************************************
    // settings in use and result capture
    // ***************************************************
    assign apply  = !conv_busy || conv_done;
    assign code_d = {HAS_UPPER ? ctlb_q[airs_pkg::CTLB_TOP] : 1'b0,
        sel_q[airs_pkg::SEL_CH_HI:0]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_q  <= airs_pkg::AIRS_REF_EXT;
            code_q <= 6'h00;
        end else if (apply) begin
            ref_q  <= airs_pkg::airs_ref_t'(sel_q[airs_pkg::SEL_REF_HI:airs_pkg::SEL_REF_LO]);
            code_q <= code_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_q <= 10'h000;
            signed_q <= 1'b0;
        end else if (conv_done) begin
            result_q <= conv_result;
            signed_q <= differential;
        end
    end

    assign reference_select = ref_q;
    assign channel_code     = code_q;
    assign result_is_signed = signed_q;

    airs_chan_decode u_dec (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .code           (code_q),
        .single_ended_q (single_ended),
        .differential_q (differential),
        .pos_input_q    (pos_input),
        .neg_input_q    (neg_input),
        .gain_q         (gain),
        .bandgap_q      (bandgap_source),
        .ground_q       (ground_select),
        .reserved_q     (reserved_code)
    );

    // ***************************************************
    // read channel
    // ***************************************************
    always_comb begin
        rd_word = 8'h00;
        if (idx_of(s_axi_araddr) == airs_pkg::IDX_RES_LO) begin
            rd_word = sel_q[airs_pkg::SEL_ALIGN] ? {result_q[1:0], 6'h00} : result_q[7:0];
        end else if (idx_of(s_axi_araddr) == airs_pkg::IDX_RES_HI) begin
            rd_word = sel_q[airs_pkg::SEL_ALIGN] ? result_q[9:2] : {6'h00, result_q[9:8]};
        end else if (idx_of(s_axi_araddr) == airs_pkg::IDX_CTRL_B) begin
            rd_word = ctlb_q;
        end else if (idx_of(s_axi_araddr) == airs_pkg::IDX_SEL) begin
            rd_word = sel_q;
        end else if (idx_of(s_axi_araddr) == airs_pkg::IDX_IRQ_STAT) begin
            rd_word = {7'h00, done_q};
        end else if (idx_of(s_axi_araddr) == airs_pkg::IDX_IRQ_MASK) begin
            rd_word = {7'h00, mask_q};
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= airs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= mapped(s_axi_araddr) ? {24'h000000, rd_word} : 32'h00000000;
            rresp_q  <= mapped(s_axi_araddr) ? airs_pkg::RESP_OKAY : airs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_busy_no_done;
        conv_busy && !conv_done;
    endsequence

    sequence seq_done_seen;
        conv_done ##1 done_q;
    endsequence

    AST_REF_FOLLOW: assert property (!conv_busy |=> ref_q == $past(sel_q[7:6]))
        else $error("reference not taken from select register");

    AST_HOLD_BUSY: assert property (seq_busy_no_done |=> $stable(ref_q) && $stable(code_q))
        else $error("setting changed during conversion");

    AST_APPLY_DONE: assert property (conv_done |-> seq_done_seen ##0 code_q == $past(code_d))
        else $error("deferred setting not applied at completion");

    AST_ALIGN_HI: assert property (s_axi_arvalid && !rvalid_q && mapped(s_axi_araddr)
        && idx_of(s_axi_araddr) == airs_pkg::IDX_RES_HI |=> s_axi_rdata[7:0] == ($past(sel_q[5])
        ? $past(result_q[9:2]) : {6'h00, $past(result_q[9:8])}))
        else $error("high result byte misaligned");

    AST_ALIGN_LO: assert property (s_axi_arvalid && !rvalid_q && mapped(s_axi_araddr)
        && idx_of(s_axi_araddr) == airs_pkg::IDX_RES_LO |=> s_axi_rdata[7:0] == ($past(sel_q[5])
        ? {$past(result_q[1:0]), 6'h00} : $past(result_q[7:0])))
        else $error("low result byte misaligned");

    AST_ALIGN_NOW: assert property (conv_busy && s_axi_arvalid && !rvalid_q && mapped(s_axi_araddr)
        && idx_of(s_axi_araddr) == airs_pkg::IDX_RES_LO |=> s_axi_rdata[7:6] == ($past(sel_q[5])
        ? $past(result_q[1:0]) : $past(result_q[7:6])))
        else $error("alignment change not immediate");

    AST_CODE_SRC: assert property (!conv_busy |=> code_q == {HAS_UPPER && $past(ctlb_q[3]), $past(sel_q[4:0])})
        else $error("channel code not assembled from both registers");

    // ***************************************************
    // decode and flag checks
    // ***************************************************
    AST_SE_DEC: assert property (code_q[4:3] == 2'b00 |=> single_ended
        && pos_input == {$past(code_q[5]), $past(code_q[2:0])})
        else $error("single input decode wrong");

    AST_BG_DEC: assert property (code_q == {1'b0, airs_pkg::CODE_BANDGAP} |=> bandgap_source && !ground_select)
        else $error("bandgap decode wrong");

    AST_GND_DEC: assert property (code_q == {1'b0, airs_pkg::CODE_GROUND} |=> ground_select && !bandgap_source)
        else $error("ground decode wrong");

    AST_GAIN_DEC: assert property (code_q[4:3] == 2'b01 |=> differential
        && gain == ($past(code_q[1]) ? airs_pkg::AIRS_GAIN_200X : airs_pkg::AIRS_GAIN_10X))
        else $error("amplified pair gain wrong");

    AST_UNITY_DEC: assert property (code_q[4:3] == 2'b10 |=> gain == airs_pkg::AIRS_GAIN_1X
        && neg_input == {$past(code_q[5]), 3'h1})
        else $error("unity pair decode wrong");

    AST_PAIR2_DEC: assert property (code_q[4:3] == 2'b11 && code_q[2:1] != 2'b11 |=> differential
        && gain == airs_pkg::AIRS_GAIN_1X && neg_input == {$past(code_q[5]), 3'h2})
        else $error("second unity pair decode wrong");

    AST_TOP_IGNORED: assert property (!HAS_UPPER |-> !code_q[5])
        else $error("top channel bit used without upper inputs");

    AST_FLAG_IRQ: assert property (conv_done && mask_q ##1 mask_q |-> irq)
        else $error("completion did not raise interrupt");

    AST_DONE_HOLD: assert property (done_q && !done_clr |=> done_q)
        else $error("done flag lost without a clear");

    AST_DONE_CLEAR: assert property (done_clr && !conv_done |=> !done_q)
        else $error("done flag not cleared");

    AST_SIGNED: assert property (conv_done |=> signed_q == $past(differential)
        && result_q == $past(conv_result))
        else $error("result capture or sign wrong");
endmodule

// >>> test/airs_conv_model.sv
// Purpose: converter stand-in driving busy, done and result
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   result lines carry the inverted held value outside the done cycle
`timescale 1ns/1ps
module airs_conv_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] len,
    input  wire logic [9:0] value,
    output logic            conv_busy,
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    logic [7:0] cnt_q;
    logic [9:0] held_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q     <= 8'h00;
            held_q    <= 10'h000;
            conv_busy <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (start && !conv_busy) begin
                conv_busy <= 1'b1;
                cnt_q     <= len;
                held_q    <= value;
            end else if (conv_busy && cnt_q == 8'h00) begin
                conv_busy <= 1'b0;
                conv_done <= 1'b1;
            end else if (conv_busy) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
    // pair results pass through as given, already two's complement
    assign conv_result = conv_done ? held_q : ~held_q;
endmodule

// >>> test/airs_top_tb_top.sv
// Purpose: self-checking bench of the select block
// Assumes: byte address is four times the register index
// Notes:   bus answers are checked by a queue monitor
`timescale 1ns/1ps
module airs_top_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] awa = 12'h000;
    logic [11:0] ara = 12'h000;
    logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        start = 1'b0;
    logic [7:0]  len = 8'h00;
    logic [9:0]  val = 10'h000;
    logic        awr, wr_rdy, bv, arr, rv, busy, done;
    logic        se, df, bg, gnd, rsv, signd, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  cres;
    logic [5:0]  code;
    logic [3:0]  pos, neg;
    logic [14:0] dec;
    airs_pkg::airs_ref_t  refs;
    airs_pkg::airs_gain_t gain;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    int          miscompares = 0;
    int          checked = 0;
    always #50 clk_sys = ~clk_sys;
    assign dec = {se, df, bg, gnd, rsv, gain, pos, neg};
    airs_top DUT (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .conv_busy(busy),
        .conv_done(done), .conv_result(cres), .reference_select(refs), .channel_code(code),
        .single_ended(se), .differential(df), .pos_input(pos), .neg_input(neg), .gain(gain),
        .bandgap_source(bg), .ground_select(gnd), .reserved_code(rsv),
        .result_is_signed(signd), .irq(irq));
    airs_conv_model PARTNER (.clk_sys(clk_sys), .rst(rst), .start(start), .len(len), .value(val),
        .conv_busy(busy), .conv_done(done), .conv_result(cres));
    // ***************************************************
    // tasks
    // ***************************************************
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    function automatic logic [14:0] exp_dec(input logic [5:0] k);
        logic [4:0] c;
        logic [3:0] u;
        c = k[4:0];
        u = {k[5], 3'h0};
        if (c < 5'h08) return {5'h10, 2'h0, {1'b0, c[2:0]} | u, 4'h0};
        if (c < 5'h10) return {5'h08, c[1] ? 2'h2 : 2'h1, {2'h0, c[2], c[0]} | u, {2'h0, c[2], 1'b0} | u};
        if (c < 5'h18) return {5'h08, 2'h0, {1'b0, c[2:0]} | u, 4'h1 | u};
        if (c < 5'h1E) return {5'h08, 2'h0, {1'b0, c[2:0]} | u, 4'h2 | u};
        if (k[5]) return 15'h0400;
        return {2'h0, ~c[0], c[0], 11'h000};
    endfunction
    function automatic logic [14:0] msk(input logic [14:0] e);
        return {5'h1F, e[13] ? 2'h3 : 2'h0, (e[14] | e[13]) ? 4'hF : 4'h0, e[13] ? 4'hF : 4'h0};
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        exp_b.push_back(er);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            if (bv) begin
                brd <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [7:0] ed);
        @(posedge clk_sys);
        exp_r.push_back({er, 24'h0, ed});
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                rrd <= 1'b0;
                break;
            end
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic go(input logic [9:0] v, input logic [7:0] l);
        @(posedge clk_sys);
        start <= 1'b1;
        val <= v;
        len <= l;
        @(posedge clk_sys);
        start <= 1'b0;
    endtask
    task automatic wait_done;
        for (int n = 0; n < 300 && done !== 1'b1; n++) @(posedge clk_sys);
        chk({33'h0, done}, 34'h1);
        wt(2);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (bv && brd && exp_b.size() > 0) chk({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        if (rv && rrd && exp_r.size() > 0) chk({rresp, rdata}, exp_r.pop_front());
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        miscompares++;
        wrap_up;
    end
    initial begin
        static logic [7:0] regs[6] = '{8'h78, 8'h79, 8'h7B, 8'h7C, 8'h80, 8'h81};
        logic [9:0]  prev;
        logic [9:0]  v;
        logic [14:0] e;
        void'($urandom(32'h0B49));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (regs[i]) rd(ad(regs[i]), airs_pkg::RESP_OKAY, 8'h00);
        rd(12'h100, airs_pkg::RESP_SLVERR, 8'h00);
        wr(12'h100, 8'hFF, airs_pkg::RESP_SLVERR);
        wr(ad(airs_pkg::IDX_CTRL_B), 8'hFF, airs_pkg::RESP_OKAY);
        rd(ad(airs_pkg::IDX_CTRL_B), airs_pkg::RESP_OKAY, airs_pkg::CTLB_WMASK);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wr(ad(airs_pkg::IDX_SEL), {k[1:0], 6'h00}, airs_pkg::RESP_OKAY);
            wt(2);
            chk({32'h0, refs}, {32'h0, k[1:0]});
        end
        $display("test reference done");
        for (int k = 0; k < 64; k++) begin
            wr(ad(airs_pkg::IDX_CTRL_B), {4'h0, k[5], 3'h0}, airs_pkg::RESP_OKAY);
            wr(ad(airs_pkg::IDX_SEL), {3'h6, k[4:0]}, airs_pkg::RESP_OKAY);
            wt(3);
            e = exp_dec(k[5:0]);
            chk({28'h0, code}, {28'h0, k[5:0]});
            chk({19'h0, dec & msk(e)}, {19'h0, e});
        end
        $display("test channel codes done");
        wr(ad(airs_pkg::IDX_CTRL_B), 8'h00, airs_pkg::RESP_OKAY);
        wr(ad(airs_pkg::IDX_SEL), 8'h45, airs_pkg::RESP_OKAY);
        go(10'h270, 8'h1E);
        wr(ad(airs_pkg::IDX_SEL), 8'hED, airs_pkg::RESP_OKAY);
        wt(1);
        chk({32'h0, refs}, 34'h1);
        chk({28'h0, code}, 34'h05);
        wait_done;
        chk({32'h0, refs}, 34'h3);
        chk({28'h0, code}, 34'h0D);
        chk({33'h0, signd}, 34'h0);
        rd(ad(airs_pkg::IDX_RES_HI), airs_pkg::RESP_OKAY, 8'h9C);
        rd(ad(airs_pkg::IDX_RES_LO), airs_pkg::RESP_OKAY, 8'h00);
        $display("test deferral done");
        prev = 10'h270;
        for (int k = 0; k < 4; k++) begin
            v = 10'($urandom);
            go(v, 8'h3C);
            wr(ad(airs_pkg::IDX_SEL), {2'h3, k[0], 5'h0D}, airs_pkg::RESP_OKAY);
            rd(ad(airs_pkg::IDX_RES_LO), airs_pkg::RESP_OKAY, k[0] ? {prev[1:0], 6'h00} : prev[7:0]);
            rd(ad(airs_pkg::IDX_RES_HI), airs_pkg::RESP_OKAY, k[0] ? prev[9:2] : {6'h00, prev[9:8]});
            wait_done;
            chk({33'h0, signd}, 34'h1);
            prev = v;
        end
        $display("test alignment done");
        wr(ad(airs_pkg::IDX_IRQ_MASK), 8'h01, airs_pkg::RESP_OKAY);
        wt(1);
        chk({33'h0, irq}, 34'h1);
        rd(ad(airs_pkg::IDX_IRQ_STAT), airs_pkg::RESP_OKAY, 8'h01);
        wr(ad(airs_pkg::IDX_IRQ_STAT), 8'h01, airs_pkg::RESP_OKAY);
        wt(1);
        chk({33'h0, irq}, 34'h0);
        rd(ad(airs_pkg::IDX_IRQ_STAT), airs_pkg::RESP_OKAY, 8'h00);
        go(10'h155, 8'h04);
        wait_done;
        chk({33'h0, irq}, 34'h1);
        wr(ad(airs_pkg::IDX_IRQ_MASK), 8'h00, airs_pkg::RESP_OKAY);
        wt(1);
        chk({33'h0, irq}, 34'h0);
        $display("test interrupt done");
        wrap_up;
    end
endmodule
